//--- tb/rco_clock_sink.sv
// consumer model: measures period and high time of the reference clock
`timescale 1ns/1ns
module rco_clock_sink (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic refClockOut,
    input wire logic refRunning,
    output int periodLen,
    output int highLen,
    output int minHigh
);
    int cnt;
    int hcnt;
    logic lastQ;
    // samples on sys_clk like a synchronous peripheral; a held output just stretches counts
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n || !refRunning) begin
            cnt = 0;
            hcnt = 0;
            lastQ = 1'b0;
            periodLen = 0;
            highLen = 0;
            minHigh = 999; // no pulse seen yet
        end else begin
            cnt++;
            if (refClockOut) hcnt++;
            if (refClockOut && !lastQ) begin
                periodLen = cnt;
                cnt = 0;
            end
            if (!refClockOut && lastQ) begin
                highLen = hcnt;
                if (hcnt < minHigh) minHigh = hcnt;
                hcnt = 0;
            end
            lastQ = refClockOut;
        end
    end
endmodule : rco_clock_sink

//--- tb/tb_top.sv
// testbench: reference clock output against a behavioural period model
`timescale 1ns/1ns
`define CHECK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic enBit = 1'b0;
    logic [1:0] srcSel = 2'h0;
    logic [2:0] divSel = 3'h0;
    logic [1:0] dutySel = 2'h0;
    logic sleepOn = 1'b0;
    logic cfgWr = 1'b0;
    logic refClockOut, refRunning, lvl;
    logic [2:0] divSetting;
    logic [1:0] dutySetting;
    int periodLen, highLen, minHigh, fails = 0, cmp_count = 0, seedVal, cases[$];
    always #25 sys_clk = ~sys_clk;
    rco_ref_clock_out u_rco_ref_clock_out (.sys_clk(sys_clk), .reset_n(reset_n), .refout_enable_bit(enBit),
        .refout_source_select(srcSel), .divSelect(divSel), .duty_select(dutySel), .sleepMode(sleepOn),
        .cfgWrite(cfgWr), .refClockOut(refClockOut), .refRunning(refRunning), .divSetting(divSetting),
        .dutySetting(dutySetting));
    rco_clock_sink u_rco_clock_sink (.sys_clk(sys_clk), .reset_n(reset_n), .refClockOut(refClockOut),
        .refRunning(refRunning), .periodLen(periodLen), .highLen(highLen), .minHigh(minHigh));
    // =========================================
    // model and drivers
    function automatic int expPer(input int s, input int d);
        return ((d == 0) ? 2 : (1 << d)) << s; // undivided toggles every tick
    endfunction : expPer
    task automatic cfg(input int s, input int d, input int u);
        @(posedge sys_clk);
        #2 {srcSel, divSel, dutySel, cfgWr} = {2'(s), 3'(d), 2'(u), 1'b1};
        @(posedge sys_clk);
        #2 cfgWr = 1'b0;
    endtask : cfg
    task automatic measure(input int s, input int d, input int u, input bit doCfg);
        int p;
        int h;
        bit quiet;
        p = expPer(s, d);
        // zero duty keeps a divided output low; the undivided rate ignores duty
        quiet = (u == 0) && (d != 0);
        h = quiet ? 0 : ((d == 0) ? p / 2 : p * u / 4);
        if (doCfg) cfg(s, d, u);
        @(posedge sys_clk);
        #2 enBit = 1'b1;
        repeat (4 * p + 8) @(posedge sys_clk);
        #2;
        `CHECK(divSetting, 3'(d), "divider latch")
        `CHECK(dutySetting, 2'(u), "duty latch")
        `CHECK(periodLen, quiet ? 0 : p, "period")
        `CHECK(highLen, h, "high time")
        `CHECK(minHigh, quiet ? 999 : h, "runt pulse")
        if (!quiet) begin
            repeat (300) begin
                @(posedge sys_clk);
                #2;
                if (refClockOut === 1'b1) break;
            end
        end else begin
            @(posedge sys_clk);
            #2;
        end
        enBit = 1'b0;
        #1 `CHECK(refClockOut, 1'b0, "stop at once")
        repeat (3) @(posedge sys_clk);
        `CHECK(refRunning, 1'b0, "idle after stop")
    endtask : measure
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // =========================================
    // watchdog: all tests need well under 20000 cycles
    initial begin
        #(50000 * 50);
        fails++;
        complete_run();
    end
    // =========================================
    // main sequence
    initial begin
        seedVal = $urandom(32'h0359);
        repeat (16) @(posedge sys_clk);
        #2 reset_n = 1'b1;
        `CHECK(dutySetting, 2'h2, "duty reset")
        `CHECK(divSetting, 3'h0, "divider reset")
        measure(0, 0, 2, 1'b0);
        $display("test reset defaults done");
        for (int d = 0; d < 8; d++) cases.push_back(d * 4 + 2);
        for (int u = 0; u < 4; u++) cases.push_back(64 + 12 + u);
        // slower sources: divide the system clock by 4 and by 8
        cases.push_back(128 + 2 * 4 + 2);
        cases.push_back(192 + 2 * 4 + 1);
        repeat (6) cases.push_back(($urandom % 2) * 64 + (2 + $urandom % 4) * 4 + 1 + $urandom % 3);
        foreach (cases[i]) measure(cases[i] / 64, (cases[i] / 4) % 16, cases[i] % 4, 1'b1);
        $display("test divider duty source done");
        cfg(0, 4, 1);
        @(posedge sys_clk);
        #2 enBit = 1'b1;
        repeat (40) @(posedge sys_clk);
        #2 sleepOn = 1'b1;
        #1 lvl = refClockOut;
        cfg(0, 2, 3);
        repeat (30) begin
            @(posedge sys_clk);
            #2 `CHECK(refClockOut, lvl, "sleep hold")
        end
        `CHECK(divSetting, 3'h4, "sleep keeps divider")
        `CHECK(dutySetting, 2'h1, "sleep keeps duty")
        sleepOn = 1'b0;
        repeat (72) @(posedge sys_clk);
        #2;
        `CHECK(periodLen, 16, "resume period")
        `CHECK(highLen, 4, "resume high")
        $display("test sleep done");
        cfg(0, 5, 3);
        repeat (136) @(posedge sys_clk);
        #2;
        `CHECK(periodLen, 32, "live period")
        `CHECK(highLen, 24, "live high")
        $display("test live change done");
        complete_run();
    end
endmodule : tb_top

//--- verilog/rco_pkg.sv
// package: constants and types of the reference clock output block
package rco_pkg;
    // =========================================
    // field widths and reset values
    localparam int DIV_W = 3;
    localparam int DUTY_W = 2;
    localparam int SRC_W = 2;
    localparam int CNT_W = 7;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [1:0] DUTY_RESET = 2'h2;
    localparam logic [1:0] SRC_RESET = 2'h0;

    // =========================================
    // duty encodings
    localparam logic [1:0] DUTY_0 = 2'h0;
    localparam logic [1:0] DUTY_25 = 2'h1;
    localparam logic [1:0] DUTY_50 = 2'h2;
    localparam logic [1:0] DUTY_75 = 2'h3;

    // =========================================
    // output state machine, gray along idle -> arm -> run
    typedef enum logic [1:0] {
        RCO_IDLE = 2'h0,
        RCO_ARM = 2'h1,
        RCO_RUN = 2'h3
    } rco_state_t;
endpackage : rco_pkg

//--- verilog/rco_ref_clock_out.sv
// reference clock output generator: divider, duty select, enable and sleep hold
`timescale 1ns/1ns
module rco_ref_clock_out #(
    parameter int DIV_W = rco_pkg::DIV_W,
    parameter int CNT_W = rco_pkg::CNT_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic refout_enable_bit,
    input wire logic [rco_pkg::SRC_W-1:0] refout_source_select,
    input wire logic [DIV_W-1:0] divSelect,
    input wire logic [rco_pkg::DUTY_W-1:0] duty_select,
    input wire logic sleepMode,
    input wire logic cfgWrite,
    output logic refClockOut,
    output logic refRunning,
    output logic [DIV_W-1:0] divSetting,
    output logic [rco_pkg::DUTY_W-1:0] dutySetting
);
    logic [DIV_W-1:0] div_q;
    logic [rco_pkg::DUTY_W-1:0] duty_q;
    logic [rco_pkg::SRC_W-1:0] src_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cntMask;
    logic out_q;
    logic out_d;
    logic tick;
    logic periodEnd;
    rco_pkg::rco_state_t state_q;

    // =========================================
    // configuration fields; written on cfgWrite, sleep leaves them alone
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= rco_pkg::DIV_RESET;
            duty_q <= rco_pkg::DUTY_RESET;
            src_q <= rco_pkg::SRC_RESET;
        end else if (cfgWrite && !sleepMode) begin
            div_q <= divSelect;
            duty_q <= duty_select;
            src_q <= refout_source_select;
        end
    end

    rco_src_select #(
        .SRC_W(rco_pkg::SRC_W)
    ) uSrc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .hold(sleepMode),
        .sourceSel(src_q),
        .srcTick(tick)
    );

    function automatic logic [CNT_W-1:0] div_mask(input logic [DIV_W-1:0] n);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1} << n;
        div_mask = CNT_W'(one - 1'b1);
    endfunction : div_mask

    assign cntMask = div_mask(div_q);
    assign periodEnd = tick && ((cnt_q & cntMask) == cntMask);

    // =========================================
    // period counter; held in sleep, cleared while idle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (state_q == rco_pkg::RCO_IDLE) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= (cnt_q + 1'b1) & cntMask;
        end
    end

    // =========================================
    // enable sequencing; arm waits for the end of a counter period so the first high phase is whole
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= rco_pkg::RCO_IDLE;
        end else if (sleepMode) begin
            state_q <= state_q;
        end else begin
            case (state_q)
                rco_pkg::RCO_IDLE: begin
                    if (refout_enable_bit) begin
                        state_q <= rco_pkg::RCO_ARM;
                    end
                end
                rco_pkg::RCO_ARM: begin
                    if (!refout_enable_bit) begin
                        state_q <= rco_pkg::RCO_IDLE;
                    end else if (periodEnd) begin
                        state_q <= rco_pkg::RCO_RUN;
                    end
                end
                rco_pkg::RCO_RUN: begin
                    if (!refout_enable_bit) begin
                        state_q <= rco_pkg::RCO_IDLE;
                    end
                end
                default: begin
                    state_q <= rco_pkg::RCO_IDLE;
                end
            endcase
        end
    end

    // =========================================
    // waveform: divided output high while counter is below the duty threshold; undivided output toggles
    always_comb begin
        logic [CNT_W+1:0] thr;
        logic [CNT_W+1:0] full;
        thr = '0;
        full = (CNT_W+2)'(cntMask) + 1'b1;
        case (duty_q)
            rco_pkg::DUTY_0: thr = '0;
            rco_pkg::DUTY_25: thr = full >> 2;
            rco_pkg::DUTY_50: thr = full >> 1;
            rco_pkg::DUTY_75: thr = (full >> 1) + (full >> 2);
            default: thr = '0;
        endcase
        if (div_q == '0) begin
            out_d = !out_q;
        end else begin
            out_d = ((CNT_W+2)'(cnt_q) < thr);
        end
    end

    // updated per source tick; counter value is the next phase
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= 1'b0;
        end else if (!refout_enable_bit && !sleepMode) begin
            out_q <= 1'b0;
        end else if (sleepMode) begin
            out_q <= out_q;
        end else if (state_q == rco_pkg::RCO_RUN && tick) begin
            out_q <= out_d;
        end else if (state_q != rco_pkg::RCO_RUN) begin
            out_q <= 1'b0;
        end
    end

    assign refClockOut = out_q && (refout_enable_bit || sleepMode);
    assign refRunning = (state_q == rco_pkg::RCO_RUN);
    assign divSetting = div_q;
    assign dutySetting = duty_q;

    // =========================================
    // checks
    // disable forces low, register cleared on the next edge
    a_disable_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!refout_enable_bit && !sleepMode) |-> !refClockOut ##1 !out_q)
        else $error("output not low after disable");
    a_stop_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (refRunning && !refout_enable_bit && !sleepMode) |=> !refRunning)
        else $error("still running after disable");
    a_start_clean: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_q != rco_pkg::RCO_RUN) |-> !out_q)
        else $error("output high before run");
    a_sleep_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sleepMode ##1 sleepMode |-> $stable(refClockOut))
        else $error("output moved in sleep");
    a_sleep_cfg: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sleepMode |=> $stable(div_q) && $stable(duty_q) && $stable(state_q))
        else $error("state changed in sleep");
    a_duty_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (duty_q == rco_pkg::DUTY_0 && div_q != '0 && !sleepMode) |=> !out_q || $past(cfgWrite))
        else $error("zero duty drove high");
    a_undiv_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (refRunning && refout_enable_bit && div_q == '0 && tick && !cfgWrite) |=> out_q != $past(out_q))
        else $error("undivided output did not toggle");
    a_cnt_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (refRunning && !cfgWrite) |=> ((cnt_q & ~cntMask) == '0))
        else $error("counter beyond divide range");
    // divide by two period; high for exactly one tick
    a_div2_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (refRunning && div_q == 3'h1 && duty_q == rco_pkg::DUTY_50 && src_q == '0 && !cfgWrite
         && !sleepMode && $rose(out_q)) |=> !out_q)
        else $error("divide by two wrong");
    c_run: cover property (@(posedge sys_clk) $rose(refRunning));
    c_live: cover property (@(posedge sys_clk) refRunning && cfgWrite);
    c_sleep: cover property (@(posedge sys_clk) refRunning && sleepMode);
    c_stop: cover property (@(posedge sys_clk) refClockOut ##1 !refout_enable_bit);
endmodule : rco_ref_clock_out

//--- verilog/rco_src_select.sv
// input clock selection: enable pulses derived from the system clock
`timescale 1ns/1ns
module rco_src_select #(
    parameter int SRC_W = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hold,
    input wire logic [SRC_W-1:0] sourceSel,
    output logic srcTick
);
    logic [SRC_W:0] preCnt_q;
    logic [SRC_W:0] preMask;

    // =========================================
    // free prescaler on the system clock; frozen while sleeping
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            preCnt_q <= '0;
        end else if (!hold) begin
            preCnt_q <= preCnt_q + 1'b1;
        end
    end

    // source n ticks every 2**n system clocks
    always_comb begin
        preMask = '0;
        for (int i = 0; i < SRC_W + 1; i++) begin
            if (i < int'(sourceSel)) begin
                preMask[i] = 1'b1;
            end
        end
    end

    assign srcTick = !hold && ((preCnt_q & preMask) == preMask);
endmodule : rco_src_select
